// >>> psctl_host.v
// host-side strobe sequencer for an asynchronous pseudo-sram
`timescale 1ns/100ps
`include "psctl_regs.vh"
module psctl_host #(
    parameter ADDR_W = 22,
    parameter IS_16M = 0,
    parameter CLK_PS = `PSCTL_CLK_PERIOD_PS,
    parameter POWERUP_LOW_CYC = (`PSCTL_POWERUP_LOW_US * 1000000 + CLK_PS - 1) / CLK_PS,
    parameter SLEEP_EXIT_CYC = (`PSCTL_SLEEP_EXIT_US * 1000000 + CLK_PS - 1) / CLK_PS,
    parameter POWERUP_HIGH_CYC = (`PSCTL_POWERUP_HIGH_US * 1000000 + CLK_PS - 1) / CLK_PS
) (
    // clock and reset
    input wire ref_clk,
    input wire rst_b,
    // user command side
    input wire wr_req,
    input wire [ADDR_W-1:0] wr_addr,
    input wire [15:0] wr_data,
    input wire [1:0] wr_lanes,
    input wire pd_req,
    input wire pd_partial,
    output reg wr_ack,
    output reg ready,
    output reg powered_down,
    // memory pins
    output reg [ADDR_W-1:0] mem_addr,
    output reg [15:0] mem_dq_out,
    output reg mem_dq_oe,
    output reg chip_select_n,
    output reg write_strobe_n,
    output reg output_enable_n,
    output reg low_byte_enable_n,
    output reg high_byte_enable_n,
    output reg power_down_select
);
    localparam W = `PSCTL_CNT_W;
    // ns figures rounded up to whole clocks
    localparam integer WC_NS = IS_16M ? `PSCTL_WRITE_CYCLE_16M_NS : `PSCTL_WRITE_CYCLE_NS;
    localparam integer WP_NS = IS_16M ? `PSCTL_WRITE_PULSE_16M_NS : `PSCTL_WRITE_PULSE_NS;
    localparam integer CP_NS = IS_16M ? `PSCTL_SELECT_HIGH_16M_NS : `PSCTL_SELECT_HIGH_NS;
    localparam integer PDH_NS = IS_16M ? `PSCTL_PD_HOLD_16M_NS : `PSCTL_PD_HOLD_NS;
    localparam integer SETUP_CYC = (`PSCTL_DATA_SETUP_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam integer PULSE_RAW = (WP_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam integer OVL_CYC = (`PSCTL_LANE_OVERLAP_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam integer PULSE_CYC = PULSE_RAW > OVL_CYC ? PULSE_RAW : OVL_CYC;
    localparam integer WC_CYC = (WC_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam integer HOLD_CYC = (`PSCTL_SELECT_HIGH_TO_CHANGE_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam integer CP_CYC = (CP_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam integer WHP_CYC = (`PSCTL_STROBE_HIGH_PS + CLK_PS - 1) / CLK_PS;
    localparam integer GAP_RAW = CP_CYC > WHP_CYC ? CP_CYC : WHP_CYC;
    localparam integer GAP_CYC = GAP_RAW > HOLD_CYC ? GAP_RAW : HOLD_CYC;
    localparam integer PDS_CYC = (`PSCTL_PD_SETUP_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam integer PDH_CYC = (PDH_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam integer PART_CYC = (`PSCTL_PARTIAL_EXIT_US * 1000000 + CLK_PS - 1) / CLK_PS;
    localparam integer RC_CYC = (`PSCTL_READ_CYCLE_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam integer FLOAT_CYC = (`PSCTL_BUS_FLOAT_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam integer SETTLE_CYC = RC_CYC + FLOAT_CYC;
    // whatever pulse is left after setup must still fill the write cycle
    localparam integer REST_CYC = WC_CYC > SETUP_CYC + PULSE_CYC ? WC_CYC - SETUP_CYC : PULSE_CYC;

    localparam [3:0] S_PWRUP_LOW = 4'h0;
    localparam [3:0] S_PWRUP_HIGH = 4'h1;
    localparam [3:0] S_IDLE = 4'h2;
    localparam [3:0] S_SETUP = 4'h3;
    localparam [3:0] S_PULSE = 4'h4;
    localparam [3:0] S_HOLD = 4'h5;
    localparam [3:0] S_GAP = 4'h6;
    localparam [3:0] S_PD_SETUP = 4'h7;
    localparam [3:0] S_PD_HOLD = 4'h8;
    localparam [3:0] S_PD = 4'h9;
    localparam [3:0] S_PD_EXIT = 4'hA;
    localparam [3:0] S_SETTLE = 4'hB;

    reg [3:0] state;
    reg [3:0] next_state;
    reg partial_mode;
    reg [W-1:0] load_val;
    reg load;
    wire tdone;
    reg wr_req_s1, wr_req_s2, pd_req_s1, pd_req_s2;
    // power-up low time is loaded once by a flag that reset clears
    reg pwrup_loaded;
    wire pwr_load = !pwrup_loaded;

    // requests may come from another clock, so resynchronise them
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_req_s1 <= 1'b0;
            wr_req_s2 <= 1'b0;
            pd_req_s1 <= 1'b0;
            pd_req_s2 <= 1'b0;
        end else begin
            wr_req_s1 <= wr_req;
            wr_req_s2 <= wr_req_s1;
            pd_req_s1 <= pd_req;
            pd_req_s2 <= pd_req_s1;
        end
    end

    psctl_timer #(.W(W)) u_timer (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .load(load),
        .cycles(load_val),
        .done(tdone)
    );

    always @* begin
        next_state = state;
        load = 1'b0;
        load_val = {W{1'b0}};
        case (state)
            S_PWRUP_LOW: begin
                if (tdone) begin
                    next_state = S_PWRUP_HIGH;
                    load = 1'b1;
                    load_val = POWERUP_HIGH_CYC[W-1:0];
                end
            end
            S_PWRUP_HIGH, S_PD_EXIT, S_SETTLE, S_GAP: begin
                if (tdone) begin
                    next_state = S_IDLE;
                end
            end
            S_IDLE: begin
                if (pd_req_s2) begin
                    next_state = S_PD_SETUP;
                    load = 1'b1;
                    load_val = PDS_CYC[W-1:0];
                end else if (wr_req_s2) begin
                    next_state = S_SETUP;
                    load = 1'b1;
                    load_val = SETUP_CYC[W-1:0];
                end
            end
            S_SETUP: begin
                if (tdone) begin
                    next_state = S_PULSE;
                    load = 1'b1;
                    load_val = REST_CYC[W-1:0];
                end
            end
            S_PULSE: begin
                if (tdone) begin
                    next_state = S_HOLD;
                    load = 1'b1;
                    load_val = HOLD_CYC[W-1:0];
                end
            end
            S_HOLD: begin
                if (tdone) begin
                    next_state = S_GAP;
                    load = 1'b1;
                    load_val = GAP_CYC[W-1:0];
                end
            end
            S_PD_SETUP: begin
                if (tdone) begin
                    next_state = S_PD_HOLD;
                    load = 1'b1;
                    load_val = PDH_CYC[W-1:0];
                end
            end
            S_PD_HOLD: begin
                if (tdone) begin
                    next_state = S_PD;
                end
            end
            S_PD: begin
                if (!pd_req_s2) begin
                    next_state = S_PD_EXIT;
                    load = 1'b1;
                    load_val = partial_mode ? PART_CYC[W-1:0] : SLEEP_EXIT_CYC[W-1:0];
                end
            end
            default: begin
                next_state = S_IDLE;
            end
        endcase
        // first clock after reset starts the power-up low interval
        if (pwr_load) begin
            load = 1'b1;
            load_val = POWERUP_LOW_CYC[W-1:0];
        end
    end

    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            pwrup_loaded <= 1'b0;
            state <= S_SETTLE;
            partial_mode <= 1'b0;
        end else begin
            pwrup_loaded <= 1'b1;
            partial_mode <= (state == S_IDLE && pd_req_s2) ? pd_partial : partial_mode;
            state <= pwr_load ? S_PWRUP_LOW : next_state;
        end
    end

    // pin drivers; select only falls with enable already high
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            chip_select_n <= 1'b1;
            write_strobe_n <= 1'b1;
            output_enable_n <= 1'b1;
            low_byte_enable_n <= 1'b1;
            high_byte_enable_n <= 1'b1;
            power_down_select <= 1'b0;
            mem_addr <= {ADDR_W{1'b0}};
            mem_dq_out <= 16'h0000;
            mem_dq_oe <= 1'b0;
            wr_ack <= 1'b0;
            ready <= 1'b0;
            powered_down <= 1'b0;
        end else begin
            wr_ack <= (state == S_HOLD) && tdone;
            ready <= (next_state == S_IDLE) && !pwr_load;
            powered_down <= (next_state == S_PD);
            output_enable_n <= 1'b1;
            power_down_select <= !(next_state == S_PWRUP_LOW || pwr_load || next_state == S_PD_HOLD
                || next_state == S_PD);
            if (state == S_IDLE && wr_req_s2 && !pd_req_s2) begin
                // address fixed for the whole cycle
                mem_addr <= wr_addr;
                mem_dq_out <= wr_data;
                mem_dq_oe <= 1'b1;
                low_byte_enable_n <= !wr_lanes[0];
                high_byte_enable_n <= !wr_lanes[1];
                chip_select_n <= 1'b0;
            end
            if (state == S_SETUP && tdone) begin
                write_strobe_n <= 1'b0;
            end
            if (state == S_PULSE && tdone) begin
                chip_select_n <= 1'b1;
            end
            if (state == S_HOLD && tdone) begin
                write_strobe_n <= 1'b1;
                low_byte_enable_n <= 1'b1;
                high_byte_enable_n <= 1'b1;
                mem_dq_oe <= 1'b0;
            end
        end
    end
endmodule // psctl_host

// >>> psctl_host_props.sv
// pin-level assertions for the pseudo-sram host
`timescale 1ns/100ps
module psctl_host_chk #(
    parameter POWERUP_LOW_CYC = 6250,
    parameter SLEEP_EXIT_CYC = 37500,
    parameter POWERUP_HIGH_CYC = 37500
) (
    // clock and reset
    input wire ref_clk,
    input wire rst_b,
    // watched ports
    input wire pd_partial,
    input wire chip_select_n,
    input wire write_strobe_n,
    input wire output_enable_n,
    input wire power_down_select
);
    reg [19:0] hi_cnt;
    reg [19:0] lo_cnt;
    reg part;
    reg from_pu;
    wire [31:0] hold_min = from_pu ? POWERUP_HIGH_CYC : part ? 32'h0000007D : SLEEP_EXIT_CYC;
    // cycles since the power-down select rose, saturating
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            hi_cnt <= 20'h00000;
            lo_cnt <= 20'h00000;
            part <= 1'b0;
            from_pu <= 1'b1;
        end else begin
            if (!power_down_select)
                hi_cnt <= 20'h00000;
            else if (hi_cnt != 20'hFFFFF)
                hi_cnt <= hi_cnt + 20'h00001;
            if (power_down_select)
                lo_cnt <= 20'h00000;
            else if (lo_cnt != 20'hFFFFF)
                lo_cnt <= lo_cnt + 20'h00001;
            if ($fell(power_down_select)) begin
                part <= pd_partial;
                from_pu <= 1'b0;
            end
        end
    end
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_b);
    sequence s_pulse;
        (!chip_select_n && !write_strobe_n)[*5];
    endsequence
    sequence s_gap;
        chip_select_n[*2];
    endsequence
    a_pulse_width: assert property ($fell(write_strobe_n) |-> s_pulse)
        else $error("write pulse too short");
    a_cycle_min: assert property ($fell(chip_select_n) |=> (!$fell(chip_select_n))[*8])
        else $error("write cycle too short");
    a_select_max: assert property ($fell(chip_select_n) |-> ##[1:125] chip_select_n)
        else $error("select low too long");
    a_oe_high: assert property (!chip_select_n |-> output_enable_n && power_down_select)
        else $error("output enable or power-down select low while selected");
    a_strobe_gap: assert property ($rose(write_strobe_n) |=> write_strobe_n)
        else $error("strobe high too short");
    a_select_gap: assert property ($rose(chip_select_n) |-> s_gap)
        else $error("select high too short");
    a_standby_hold: assert property ($rose(chip_select_n) |=> $stable(write_strobe_n) && $stable(output_enable_n))
        else $error("strobe moved after deselect");
    a_pd_entry: assert property ($fell(power_down_select) |-> $past(chip_select_n, 2) && chip_select_n
            ##1 (!power_down_select)[*8])
        else $error("power-down entry timing");
    a_exit_wait: assert property ($fell(chip_select_n) |-> hi_cnt >= hold_min)
        else $error("select low too soon after power-down exit");
    a_powerup_low: assert property ($rose(power_down_select) && from_pu |-> lo_cnt >= POWERUP_LOW_CYC)
        else $error("power-down select released too early at power-up");
endmodule // psctl_host_chk
bind psctl_host psctl_host_chk #(
    .POWERUP_LOW_CYC(POWERUP_LOW_CYC),
    .SLEEP_EXIT_CYC(SLEEP_EXIT_CYC),
    .POWERUP_HIGH_CYC(POWERUP_HIGH_CYC)
) u_chk (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .pd_partial(pd_partial),
    .chip_select_n(chip_select_n),
    .write_strobe_n(write_strobe_n),
    .output_enable_n(output_enable_n),
    .power_down_select(power_down_select)
);

// >>> psctl_host_tb.sv
// self-checking bench for the pseudo-sram host controller
`timescale 1ns/100ps
module psctl_host_tb;
    localparam ADDR_W = 22;
    reg ref_clk = 1'b0;
    reg rst_b = 1'b0;
    reg wr_req = 1'b0;
    reg [ADDR_W-1:0] wr_addr = 22'h000000;
    reg [15:0] wr_data = 16'h0000;
    reg [1:0] wr_lanes = 2'h0;
    reg pd_req = 1'b0;
    reg pd_partial = 1'b0;
    wire wr_ack, ready, powered_down, mem_dq_oe, chip_select_n, write_strobe_n, output_enable_n;
    wire low_byte_enable_n, high_byte_enable_n, power_down_select;
    wire [ADDR_W-1:0] mem_addr;
    wire [15:0] mem_dq_out;
    reg [15:0] dq_last = 16'h0000;
    // released bus must not keep showing the last word
    wire [15:0] mem_dq = mem_dq_oe ? mem_dq_out : ~dq_last;
    reg [15:0] shadow [0:15];
    reg [3:0] exp_addr [$];
    reg [15:0] exp_data [$];
    integer errors = 0;
    integer comparisons = 0;
    integer cycles = 0;
    integer i;
    psctl_host #(.ADDR_W(ADDR_W), .IS_16M(0), .CLK_PS(8000), .POWERUP_LOW_CYC(20),
        .SLEEP_EXIT_CYC(300), .POWERUP_HIGH_CYC(300)) dut (
        .ref_clk(ref_clk), .rst_b(rst_b), .wr_req(wr_req), .wr_addr(wr_addr), .wr_data(wr_data),
        .wr_lanes(wr_lanes), .pd_req(pd_req), .pd_partial(pd_partial), .wr_ack(wr_ack), .ready(ready),
        .powered_down(powered_down), .mem_addr(mem_addr), .mem_dq_out(mem_dq_out), .mem_dq_oe(mem_dq_oe),
        .chip_select_n(chip_select_n), .write_strobe_n(write_strobe_n), .output_enable_n(output_enable_n),
        .low_byte_enable_n(low_byte_enable_n), .high_byte_enable_n(high_byte_enable_n),
        .power_down_select(power_down_select));
    psctl_sram_model #(.ADDR_W(ADDR_W)) mdl (
        .mem_addr(mem_addr), .mem_dq(mem_dq), .chip_select_n(chip_select_n), .write_strobe_n(write_strobe_n),
        .output_enable_n(output_enable_n), .low_byte_enable_n(low_byte_enable_n),
        .high_byte_enable_n(high_byte_enable_n), .power_down_select(power_down_select));
    initial begin
        forever #4 ref_clk = ~ref_clk;
    end
    task chk(input [15:0] seen, input [15:0] want);
        begin
            comparisons = comparisons + 1;
            if (seen !== want) begin
                errors = errors + 1;
                $display("MISMATCH %0t seen %h expected %h", $time, seen, want);
            end
        end
    endtask
    task conclude;
        begin
            if (errors == 0 && comparisons > 0)
                $display("All tests passed");
            else
                $display("Some tests failed");
            $finish;
        end
    endtask
    task do_write(input [3:0] a, input [15:0] d, input [1:0] l);
        begin
            @(negedge ref_clk);
            while (ready !== 1'b1)
                @(negedge ref_clk);
            @(posedge ref_clk);
            wr_req <= 1'b1;
            wr_addr <= {18'($urandom), a};
            wr_data <= d;
            wr_lanes <= l;
            if (l[0])
                shadow[a][7:0] = d[7:0];
            if (l[1])
                shadow[a][15:8] = d[15:8];
            exp_addr.push_back(a);
            exp_data.push_back(shadow[a]);
            @(negedge ref_clk);
            while (wr_ack !== 1'b1)
                @(negedge ref_clk);
            @(posedge ref_clk);
            wr_req <= 1'b0;
        end
    endtask
    // hang guard, far above the longest expected run
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (mem_dq_oe === 1'b1)
            dq_last <= mem_dq_out;
        if (cycles == 20000) begin
            errors = errors + 1;
            conclude;
        end
    end
    always @(negedge ref_clk) begin
        if (wr_ack === 1'b1) begin
            if (exp_addr.size() == 0)
                chk(16'hFFFF, 16'h0000);
            else
                chk(mdl.mem[exp_addr.pop_front()], exp_data.pop_front());
        end
    end
    initial begin
        for (i = 0; i < 16; i = i + 1)
            shadow[i] = 16'h0000;
        void'($urandom(51273));
        repeat (6) @(posedge ref_clk);
        @(negedge ref_clk);
        chk({power_down_select, chip_select_n, write_strobe_n}, 16'h0003);
        repeat (6) @(posedge ref_clk);
        rst_b <= 1'b1;
        for (i = 1; i < 4; i = i + 1)
            do_write(4'h5, 16'($urandom), i[1:0]);
        chk(power_down_select, 1'b1);
        for (i = 0; i < 8; i = i + 1)
            do_write(4'($urandom), 16'($urandom), 2'($urandom % 3) + 2'h1);
        // deep sleep then partial mode, each followed by a write
        for (i = 0; i < 2; i = i + 1) begin
            @(posedge ref_clk);
            pd_partial <= i[0];
            pd_req <= 1'b1;
            @(negedge ref_clk);
            while (powered_down !== 1'b1)
                @(negedge ref_clk);
            chk(power_down_select, 1'b0);
            repeat (20) @(posedge ref_clk);
            pd_req <= 1'b0;
            do_write(4'h9, 16'($urandom), 2'h3);
        end
        repeat (10) @(posedge ref_clk);
        chk(mdl.read_seen, 1'b0);
        chk(16'(exp_addr.size()), 16'h0000);
        conclude;
    end
endmodule // psctl_host_tb

// >>> psctl_regs.vh
// timing constants for the pseudo-sram host controller
`ifndef PSCTL_REGS_VH
`define PSCTL_REGS_VH
`define PSCTL_CLK_PERIOD_PS 8000
`define PSCTL_WRITE_CYCLE_NS 65
`define PSCTL_WRITE_CYCLE_16M_NS 70
`define PSCTL_READ_CYCLE_NS 65
`define PSCTL_WRITE_PULSE_NS 40
`define PSCTL_WRITE_PULSE_16M_NS 45
`define PSCTL_DATA_SETUP_NS 15
`define PSCTL_LANE_OVERLAP_NS 30
`define PSCTL_STROBE_HIGH_PS 7500
`define PSCTL_SELECT_HIGH_NS 12
`define PSCTL_SELECT_HIGH_16M_NS 10
`define PSCTL_SELECT_HIGH_TO_CHANGE_NS 10
`define PSCTL_BUS_FLOAT_NS 20
`define PSCTL_MAX_SELECT_LOW_NS 1000
`define PSCTL_PD_SETUP_NS 10
`define PSCTL_PD_HOLD_NS 65
`define PSCTL_PD_HOLD_16M_NS 80
`define PSCTL_SLEEP_EXIT_US 300
`define PSCTL_PARTIAL_EXIT_US 1
`define PSCTL_POWERUP_LOW_US 50
`define PSCTL_POWERUP_HIGH_US 300
`define PSCTL_CNT_W 20
`endif

// >>> psctl_sram_model.sv
// behavioural pseudo-sram write path
`timescale 1ns/100ps
module psctl_sram_model #(
    parameter ADDR_W = 22
) (
    // host pins
    input wire [ADDR_W-1:0] mem_addr,
    input wire [15:0] mem_dq,
    input wire chip_select_n,
    input wire write_strobe_n,
    input wire output_enable_n,
    input wire low_byte_enable_n,
    input wire high_byte_enable_n,
    input wire power_down_select
);
    reg [15:0] mem [0:15];
    reg [1:0] lane = 2'h0;
    reg read_seen = 1'b0;
    integer i;
    // array frozen while powered down
    wire pulse = power_down_select & ~chip_select_n & ~write_strobe_n
        & ~(low_byte_enable_n & high_byte_enable_n);
    initial begin
        for (i = 0; i < 16; i = i + 1)
            mem[i] = 16'h0000;
    end
    always @(posedge pulse)
        lane = ~{high_byte_enable_n, low_byte_enable_n};
    // zero recovery: commit on the first rising edge
    always @(negedge pulse) begin
        if (lane[0] === 1'b1)
            mem[mem_addr[3:0]][7:0] = mem_dq[7:0];
        if (lane[1] === 1'b1)
            mem[mem_addr[3:0]][15:8] = mem_dq[15:8];
    end
    always @(negedge chip_select_n) begin
        #5;
        if (!chip_select_n && !output_enable_n)
            read_seen = 1'b1;
    end
endmodule // psctl_sram_model

// >>> psctl_timer.v
// down-counter that measures one minimum interval
`timescale 1ns/100ps
module psctl_timer #(
    parameter W = 20
) (
    // clock and reset
    input wire ref_clk,
    input wire rst_b,
    // control
    input wire load,
    input wire [W-1:0] cycles,
    // status
    output wire done
);
    reg [W-1:0] count;

    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            count <= {W{1'b0}};
        end else if (load) begin
            count <= cycles;
        end else if (count != {W{1'b0}}) begin
            count <= count - {{(W-1){1'b0}}, 1'b1};
        end
    end

    assign done = (count == {W{1'b0}});
endmodule // psctl_timer
